// ===== rtl/acfc_flow_ctrl.v
// What this block does
// - Trigger line rising edge or bus write sets start flag, starting sequence.
// - Start flag clears when first conversion begins sampling.
// - Start flag is set only while converter and sequence are idle, or by a start overrun.
// - Restart mode: trigger during restart load sets start overrun error.
// - Trigger mode: restart sets start flag automatically once idle and list done.
// - Trigger mode: restart together with trigger sets overrun error and halts.
// - Plain restart clears index, loads one command, keeps list selection.
// - Restart line rising edge or bus write sets restart flag.
// - Restart flag clears once first command from list top is loaded.
// - Restart sets cancel flag too when running or idle with list not done.
// - Restart before end of list or cancel sets early restart error.
// - Swap permit sampled on restart line edge; software writes both bits.
// - Swap with double buffering clears index and selects other list.
// - Swap and restart flags clear together after first command load.
// - Swap permit must be high no later than restart edge.
// - Cancel stops conversion at next boundary and abandons list.
// - Cancel line rising edge or bus write requests cancel anytime.
// - Cancel flag clears when converter idle or at next sequence boundary, then marks list done.
// - Cancel flag sets only when running or idle with list not done.
// - Restart mode: trigger after cancel before restart completes is overrun.
// - Automatic cancel from restart also sets early restart error.
// - Trigger while start flag set is overrun; stop and flag error.
// - Severe errors halt converter until soft reset clears them.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "acfc_regs.vh"
module acfc_flow_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Internal interface lines from on-chip sources
  input  wire        trigger_in,
  input  wire        restart_in,
  input  wire        cancel_in,
  input  wire        swap_permit_in,
  // Sequencer status
  input  wire        seq_busy,
  input  wire        sample_begin,
  input  wire        cmd_loaded,
  input  wire        eol_executed,
  input  wire        eol_pending,
  input  wire        seq_boundary,
  // Sequencer controls
  output reg         conv_start_flag,
  output reg         list_restart_flag,
  output reg         list_swap_flag,
  output reg         sequence_cancel_flag,
  output reg         start_overrun_error,
  output reg         early_restart_error,
  output reg         cmd_index_clear,
  output reg         cmd_load_req,
  output reg         list_sel,
  output reg         conv_halt,
  output reg         cancel_now
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_RUN    = 2'h1;
  localparam ST_DONE   = 2'h2;
  localparam ST_HALT   = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         restart_mode;
  reg         cmd_list_double_buffer;
  reg         eol_abort_option;
  reg         list_done;
  reg         cancel_executed;
  reg         auto_conv_start_flag_pend;
  wire [3:0]  sync_lines;
  wire [2:0]  rise;
  wire        wr_en;
  wire        rd_en;
  wire        hit_flow;
  wire        hit_cfg;
  wire        hit_stat;
  wire        hit_srst;
  wire        soft_reset;
  wire        bus_conv_start_flag;
  wire        bus_list_restart_flag;
  wire        bus_swap;
  wire        bus_cancel;
  wire        conv_start_flag_req;
  wire        list_restart_flag_req;
  wire        cancel_req;
  wire        swap_req;
  wire        idle;
  wire        rvl_done;
  wire        auto_cancel;
  wire        cancel_set;
  wire        legal_restart;
  wire        conv_start_flag_overrun;
  wire        auto_conv_start_flag;
  wire        pend_fire;
  wire        ovr_double;
  wire        ovr_pair;
  wire        ovr_load;
  wire        ovr_abort;

  function addr_hit;
    input [11:0] a;
    input [11:0] match;
    begin
      addr_hit = (a == match);
    end
  endfunction

  // Lines sampled
  // Swap permit rides the same two stages as restart so that
  // both are seen in the same cycle
  // two-stage sync
  acfc_sync2 #(.WIDTH(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     ({swap_permit_in, cancel_in, restart_in, trigger_in}),
    .dout    (sync_lines)
  );

  acfc_edge #(.WIDTH(3)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .level   (sync_lines[2:0]),
    .rise    (rise)
  );

  // Zero-wait slave: the access phase always ends at its first edge
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign wr_en    = psel & penable & pwrite & ce;
  assign rd_en    = psel & ~pwrite;
  assign hit_flow = addr_hit(paddr, `ACFC_ADDR_FLOW);
  assign hit_cfg  = addr_hit(paddr, `ACFC_ADDR_CONFIG);
  assign hit_stat = addr_hit(paddr, `ACFC_ADDR_STATUS);
  assign hit_srst = addr_hit(paddr, `ACFC_ADDR_SOFTRST);

  assign soft_reset = wr_en & hit_srst & pwdata[`ACFC_B_SOFTRST];
  assign bus_conv_start_flag   = wr_en & hit_flow & pwdata[`ACFC_B_START];
  assign bus_list_restart_flag   = wr_en & hit_flow & pwdata[`ACFC_B_RESTART];
  assign bus_swap   = bus_list_restart_flag & pwdata[`ACFC_B_SWAP];
  assign bus_cancel = wr_en & hit_flow & pwdata[`ACFC_B_CANCEL];

  assign conv_start_flag_req   = rise[0] | bus_conv_start_flag;
  assign list_restart_flag_req   = rise[1] | bus_list_restart_flag;
  assign cancel_req = rise[2] | bus_cancel;
  assign swap_req   = (rise[1] & sync_lines[3]) | bus_swap;

  // Idle needs a quiet sequencer and no run left open
  assign idle     = ~seq_busy & (state != ST_RUN);
  // A cancel set or requested now already counts as done
  assign rvl_done = list_done | sequence_cancel_flag | cancel_req;

  assign auto_cancel = list_restart_flag_req & ~list_restart_flag &
                       ((~idle & ~sequence_cancel_flag & ~cancel_req) | (idle & ~rvl_done));
  assign cancel_set  = ((cancel_req & (~idle | ~list_done)) | auto_cancel) & ~sequence_cancel_flag;

  assign legal_restart = list_done | (eol_abort_option & eol_pending) |
                         sequence_cancel_flag | cancel_req | cancel_executed;

  // deferred start once idle and done
  assign pend_fire = ~restart_mode & auto_conv_start_flag_pend & idle & rvl_done;
  assign auto_conv_start_flag = (~restart_mode & list_restart_flag_req & idle & rvl_done) | pend_fire;

  assign ovr_double   = conv_start_flag_req & conv_start_flag;
  assign ovr_pair     = conv_start_flag_req & ~restart_mode & (list_restart_flag_req | pend_fire);
  assign ovr_load     = conv_start_flag_req & restart_mode & list_restart_flag;
  assign ovr_abort    = conv_start_flag_req & restart_mode & cancel_executed & ~list_restart_flag & ~list_restart_flag_req;
  assign conv_start_flag_overrun = ovr_double | ovr_pair | ovr_load | ovr_abort;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sample_begin)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (eol_executed | (sequence_cancel_flag & seq_boundary))
          next_state = ST_DONE;
      end
      ST_DONE: begin
        if (sample_begin)
          next_state = ST_RUN;
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (conv_start_flag_overrun)
      next_state = ST_HALT;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_IDLE;
      restart_mode           <= 1'b0;
      cmd_list_double_buffer <= 1'b0;
      eol_abort_option       <= 1'b0;
      list_done              <= 1'b0;
      cancel_executed        <= 1'b0;
      auto_conv_start_flag_pend         <= 1'b0;
      conv_start_flag        <= 1'b0;
      list_restart_flag      <= 1'b0;
      list_swap_flag         <= 1'b0;
      sequence_cancel_flag   <= 1'b0;
      start_overrun_error    <= 1'b0;
      early_restart_error    <= 1'b0;
      cmd_index_clear        <= 1'b0;
      cmd_load_req           <= 1'b0;
      list_sel               <= 1'b0;
      conv_halt              <= 1'b0;
      cancel_now             <= 1'b0;
    end else if (ce) begin
      cmd_index_clear <= 1'b0;
      cmd_load_req    <= 1'b0;
      cancel_now      <= 1'b0;
      // Config survives a soft reset
      if (wr_en & hit_cfg) begin
        restart_mode           <= pwdata[`ACFC_B_RSTMODE];
        cmd_list_double_buffer <= pwdata[`ACFC_B_DBLBUF];
        eol_abort_option       <= pwdata[`ACFC_B_EOLABORT];
      end
      if (soft_reset) begin
        state                <= ST_IDLE;
        start_overrun_error  <= 1'b0;
        conv_halt            <= 1'b0;
        conv_start_flag      <= 1'b0;
        list_restart_flag    <= 1'b0;
        list_swap_flag       <= 1'b0;
        sequence_cancel_flag <= 1'b0;
        early_restart_error  <= 1'b0;
        list_done            <= 1'b0;
        cancel_executed      <= 1'b0;
        auto_conv_start_flag_pend       <= 1'b0;
      end else begin
        state <= next_state;
        if (eol_executed)
          list_done <= 1'b1;
        else if (sample_begin)
          list_done <= 1'b0;

        if (conv_start_flag_overrun) begin
          start_overrun_error <= 1'b1;
          conv_halt           <= 1'b1;
          conv_start_flag     <= 1'b1;
        end else if (state != ST_HALT) begin
          if ((conv_start_flag_req & idle & ~conv_start_flag) | auto_conv_start_flag)
            conv_start_flag <= 1'b1;
          else if (sample_begin)
            conv_start_flag <= 1'b0;
        end

        if (cancel_set) begin
          sequence_cancel_flag <= 1'b1;
          cancel_now           <= 1'b1;
        end else if (sequence_cancel_flag & (idle | seq_boundary)) begin
          sequence_cancel_flag <= 1'b0;
          cancel_executed      <= 1'b1;
          list_done            <= 1'b1;
        end

        if (auto_cancel | (list_restart_flag_req & ~legal_restart))
          early_restart_error <= 1'b1;

        if (~restart_mode & list_restart_flag_req & ~list_restart_flag & ~(idle & rvl_done))
          auto_conv_start_flag_pend <= 1'b1;
        else if (pend_fire | restart_mode | conv_start_flag_overrun)
          auto_conv_start_flag_pend <= 1'b0;

        if (list_restart_flag_req & ~list_restart_flag) begin
          list_restart_flag <= 1'b1;
          cmd_index_clear   <= 1'b1;
          cmd_load_req      <= 1'b1;
          cancel_executed   <= 1'b0;
          if (swap_req) begin
            list_swap_flag <= 1'b1;
            if (cmd_list_double_buffer)
              list_sel <= ~list_sel;
          end
        end else if (list_restart_flag & cmd_loaded) begin
          list_restart_flag <= 1'b0;
          list_swap_flag    <= 1'b0;
          cancel_executed   <= 1'b0;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce) begin
      // Loaded in setup so the word stands through the access cycle
      prdata <= 32'h00000000;
      if (rd_en & hit_flow)
        prdata <= {28'h0000000, sequence_cancel_flag, list_swap_flag, list_restart_flag, conv_start_flag};
      else if (rd_en & hit_cfg)
        prdata <= {29'h0, eol_abort_option, cmd_list_double_buffer, restart_mode};
      else if (rd_en & hit_stat)
        prdata <= {26'h0, ~idle, list_done, list_sel, conv_halt, early_restart_error,
                   start_overrun_error};
    end
  end
endmodule // acfc_flow_ctrl

// ===== shared/acfc_regs.vh
`ifndef ACFC_REGS_VH
`define ACFC_REGS_VH

// Register byte addresses
`define ACFC_ADDR_FLOW      12'h000
`define ACFC_ADDR_CONFIG    12'h004
`define ACFC_ADDR_STATUS    12'h008
`define ACFC_ADDR_SOFTRST   12'h00c
`define ACFC_ADDR_W         12

// Flow control register bits
`define ACFC_B_START        0
`define ACFC_B_RESTART      1
`define ACFC_B_SWAP         2
`define ACFC_B_CANCEL       3

// Config register bits
`define ACFC_B_RSTMODE      0
`define ACFC_B_DBLBUF       1
`define ACFC_B_EOLABORT     2

// Status register bits
`define ACFC_B_OVR_ERR      0
`define ACFC_B_EARLY_ERR    1
`define ACFC_B_HALTED       2
`define ACFC_B_LIST_SEL     3
`define ACFC_B_LIST_DONE    4
`define ACFC_B_BUSY         5

// Soft reset key bit
`define ACFC_B_SOFTRST      0

`define ACFC_CFG_RESET      3'h0

`endif

// ===== rtl/acfc_sync2.v
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pin levels
module acfc_sync2 #(
  parameter WIDTH = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else if (ce) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // acfc_sync2

// ===== rtl/acfc_edge.v
`timescale 1ns/1ps
// Rising edge detection on synchronised lines
module acfc_edge #(
  parameter WIDTH = 3
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             ce,
  input  wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise
);
  reg [WIDTH-1:0] level_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= {WIDTH{1'b0}};
    end else if (ce) begin
      level_q <= level;
    end
  end

  assign rise = level & ~level_q & {WIDTH{ce}};
endmodule // acfc_edge

// ===== dv/acfc_props.sv
`timescale 1ns/1ps
`include "acfc_regs.vh"
module acfc_props (
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        seq_busy,
  input logic        sample_begin,
  input logic        cmd_loaded,
  input logic        conv_start_flag,
  input logic        list_restart_flag,
  input logic        list_swap_flag,
  input logic        sequence_cancel_flag,
  input logic        start_overrun_error,
  input logic        early_restart_error,
  input logic        list_sel,
  input logic        conv_halt,
  input logic        cmd_index_clear
);
  logic wr;
  logic srst;
  assign wr   = psel & penable & pwrite & ce;
  assign srst = wr & (paddr == `ACFC_ADDR_SOFTRST) & pwdata[`ACFC_B_SOFTRST];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_start_idle: assert property ($rose(conv_start_flag) |-> !$past(seq_busy))
    else $error("start flag set while busy");
  a_start_clr: assert property (sample_begin && !wr |=> !conv_start_flag)
    else $error("start flag kept after sampling began");
  a_halt_hold: assert property (conv_halt && !srst |=> conv_halt)
    else $error("halt left without soft reset");
  a_ovr_halt: assert property ($rose(start_overrun_error) |-> ##[0:2] conv_halt)
    else $error("overrun did not halt");
  a_rst_clr: assert property (list_restart_flag && cmd_loaded && !wr |=> !list_restart_flag)
    else $error("restart flag kept after load");
  a_swap_pair: assert property ($fell(list_swap_flag) |-> $fell(list_restart_flag))
    else $error("swap flag cleared alone");
  a_sel_swap: assert property ($changed(list_sel) |-> list_swap_flag || $past(list_swap_flag))
    else $error("list select moved without swap");
  a_idx_clr: assert property ($rose(list_restart_flag) |-> cmd_index_clear)
    else $error("restart without index clear");
  a_early_err: assert property ($rose(sequence_cancel_flag) && $rose(list_restart_flag)
    |-> ##[0:1] early_restart_error)
    else $error("auto cancel without early error");
endmodule // acfc_props

// ===== dv/acfc_seq_model.sv
`timescale 1ns/1ps
module acfc_seq_model (
  input  logic pclk,
  input  logic presetn,
  input  logic conv_start_flag,
  input  logic cmd_load_req,
  input  logic cancel_now,
  input  logic conv_halt,
  input  logic stall,
  output logic seq_busy,
  output logic sample_begin,
  output logic cmd_loaded,
  output logic eol_executed,
  output logic eol_pending,
  output logic seq_boundary
);
  logic [3:0] cnt;
  assign eol_pending = seq_busy & (cnt == 4'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {seq_busy, sample_begin, cmd_loaded, eol_executed, seq_boundary} <= '0;
      cnt <= 4'h0;
    end else begin
      sample_begin <= 1'b0;
      cmd_loaded   <= cmd_load_req;
      eol_executed <= 1'b0;
      seq_boundary <= 1'b0;
      // Stall keeps a start pending so the flag can be observed
      if (!seq_busy && !sample_begin && conv_start_flag && !conv_halt && !stall) begin
        sample_begin <= 1'b1;
        seq_busy     <= 1'b1;
        cnt          <= 4'hc;
      end else if (seq_busy) begin
        cnt <= cnt - 4'h1;
        // Cancel ends the run here without an end of list
        if (cnt == 4'h1 || cancel_now) begin
          seq_busy     <= 1'b0;
          seq_boundary <= 1'b1;
          eol_executed <= !cancel_now;
        end
      end
    end
  end
endmodule // acfc_seq_model

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "acfc_regs.vh"
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        trigger_in = 1'b0;
  logic        restart_in = 1'b0;
  logic        cancel_in = 1'b0;
  logic        swap_permit_in = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, seq_busy, sample_begin, cmd_loaded, eol_executed, eol_pending, seq_boundary, cancel_now;
  logic        conv_start_flag, list_restart_flag, list_swap_flag, sequence_cancel_flag, cmd_load_req;
  logic        start_overrun_error, early_restart_error, cmd_index_clear, list_sel, conv_halt;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;
  always #50 pclk = ~pclk;
  acfc_flow_ctrl u_acfc_flow_ctrl (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr(), .trigger_in, .restart_in, .cancel_in, .swap_permit_in, .seq_busy, .sample_begin, .cmd_loaded,
    .eol_executed, .eol_pending, .seq_boundary, .conv_start_flag, .list_restart_flag, .list_swap_flag,
    .sequence_cancel_flag, .start_overrun_error, .early_restart_error, .cmd_index_clear, .cmd_load_req, .list_sel,
    .conv_halt, .cancel_now);
  acfc_seq_model u_acfc_seq_model (.pclk, .presetn, .conv_start_flag, .cmd_load_req, .cancel_now, .conv_halt, .stall,
    .seq_busy, .sample_begin, .cmd_loaded, .eol_executed, .eol_pending, .seq_boundary);
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run;
    stall <= 1'b0;
    wait (seq_busy === 1'b1);
    wait (seq_busy === 1'b0);
    @(negedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({conv_start_flag, list_restart_flag, list_swap_flag, sequence_cancel_flag, conv_halt}, 0);
    @(posedge pclk);
    ce <= 1'b0;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    chk(conv_start_flag, 0);
    @(posedge pclk);
    ce <= 1'b1;
    bus(1'b0, `ACFC_ADDR_CONFIG, 0);
    chk(rd, `ACFC_CFG_RESET);
    bus(1'b0, 12'h010, 0);
    chk(rd, 0);
    stall <= 1'b1;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    chk(conv_start_flag, 1);
    stall <= 1'b0;
    wait (seq_busy === 1'b1);
    repeat (2) @(negedge pclk);
    chk(conv_start_flag, 0);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    chk({conv_start_flag, start_overrun_error}, 0);
    wait (seq_busy === 1'b0);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h8);
    chk(sequence_cancel_flag, 0);
    stall <= 1'b1;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h2);
    chk(list_restart_flag, 1);
    wait (list_restart_flag === 1'b0);
    repeat (2) @(negedge pclk);
    chk({conv_start_flag, list_sel, early_restart_error}, 3'b100);
    stall <= 1'b0;
    wait (seq_busy === 1'b1);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h2);
    chk({sequence_cancel_flag, early_restart_error}, 2'b11);
    stall <= 1'b1;
    wait (seq_busy === 1'b0 && list_restart_flag === 1'b0);
    repeat (2) @(negedge pclk);
    chk({sequence_cancel_flag, conv_start_flag}, 2'b01);
    run();
    bus(1'b1, `ACFC_ADDR_CONFIG, 32'h2);
    stall <= 1'b1;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h6);
    chk(list_swap_flag, 1);
    wait (list_restart_flag === 1'b0);
    repeat (2) @(negedge pclk);
    chk({list_swap_flag, list_sel}, 2'b01);
    run();
    @(posedge pclk);
    restart_in <= 1'b1;
    wait (list_restart_flag === 1'b1);
    @(posedge pclk);
    swap_permit_in <= 1'b1;
    wait (list_restart_flag === 1'b0);
    run();
    chk(list_sel, 1);
    @(posedge pclk);
    restart_in <= 1'b0;
    @(posedge pclk);
    restart_in <= 1'b1;
    wait (list_restart_flag === 1'b1);
    wait (list_restart_flag === 1'b0);
    run();
    chk(list_sel, 0);
    @(posedge pclk);
    restart_in <= 1'b0;
    swap_permit_in <= 1'b0;
    trigger_in <= 1'b1;
    n = 0;
    while (conv_start_flag !== 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk(n, 4);
    run();
    stall <= 1'b1;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h3);
    @(negedge pclk);
    chk({start_overrun_error, conv_halt}, 2'b11);
    bus(1'b1, `ACFC_ADDR_SOFTRST, 32'h1);
    chk({start_overrun_error, early_restart_error, conv_halt}, 0);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    @(negedge pclk);
    chk({start_overrun_error, conv_halt}, 2'b11);
    bus(1'b1, `ACFC_ADDR_SOFTRST, 32'h1);
    bus(1'b1, `ACFC_ADDR_CONFIG, 32'h1);
    stall <= 1'b0;
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    wait (seq_busy === 1'b1);
    @(posedge pclk);
    cancel_in <= 1'b1;
    n = 0;
    while (seq_busy !== 1'b0) begin
      @(negedge pclk);
      n++;
    end
    chk(n < 10, 1);
    stall <= 1'b1;
    wait (sequence_cancel_flag === 1'b0);
    bus(1'b1, `ACFC_ADDR_FLOW, 32'h1);
    @(negedge pclk);
    chk({conv_start_flag, start_overrun_error}, 2'b11);
    bus(1'b1, `ACFC_ADDR_SOFTRST, 32'h1);
    @(posedge pclk);
    trigger_in <= 1'b0;
    repeat (3) @(posedge pclk);
    restart_in <= 1'b1;
    @(posedge pclk);
    trigger_in <= 1'b1;
    repeat (4) @(negedge pclk);
    chk({start_overrun_error, conv_halt}, 2'b11);
    close_out();
  end
endmodule // tb
bind acfc_flow_ctrl acfc_props u_acfc_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .seq_busy,
  .sample_begin, .cmd_loaded, .conv_start_flag, .list_restart_flag, .list_swap_flag, .sequence_cancel_flag,
  .start_overrun_error, .early_restart_error, .list_sel, .conv_halt, .cmd_index_clear);
